// ==== motion_pkg.sv ====
package motion_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam int          AXI_AW      = 8;
  localparam logic [7:0]  CMD_OFS     = 8'h00;
  localparam logic [7:0]  BASE_OFS    = 8'h04;
  localparam logic [7:0]  DRIVE_OFS   = 8'h08;
  localparam logic [7:0]  ERRSEL_OFS  = 8'h0C;
  localparam logic [7:0]  ERRALL_OFS  = 8'h10;
  localparam logic [7:0]  ERRLO_OFS   = 8'h14;
  localparam logic [7:0]  ERRHI_OFS   = 8'h18;
  localparam logic [7:0]  FIRST_OFS   = 8'h1C;
  localparam logic [7:0]  HOME_OFS    = 8'h20;
  localparam logic [7:0]  RESTART_OFS = 8'h24;
  localparam logic [7:0]  STAT_OFS    = 8'h28;
  localparam logic [7:0]  IRQST_OFS   = 8'h30;
  localparam logic [7:0]  IRQCLR_OFS  = 8'h34;
  localparam logic [7:0]  IRQEN_OFS   = 8'h38;
  localparam logic [7:0]  AXSEL_OFS   = 8'h40;
  localparam logic [7:0]  UNITS_OFS   = 8'h44;
  localparam logic [7:0]  SPEED_OFS   = 8'h48;
  localparam logic [7:0]  ACCELERATION_RATE_OFS   = 8'h4C;
  localparam logic [7:0]  DECELERATION_RATE_OFS   = 8'h50;
  localparam logic [7:0]  MERGE_OFS   = 8'h54;
  localparam logic [7:0]  POS_OFS     = 8'h58;
  localparam logic [7:0]  ARG_OFS     = 8'h80;

  // ==========================================================
  // field positions and reset values
  localparam int          ERR_SPLIT   = 16;
  localparam int          IRQ_ERR     = 0;
  localparam int          IRQ_DONE    = 1;
  localparam int          IRQ_REFUSE  = 2;
  localparam int          IRQ_W       = 3;
  localparam logic [31:0] UNITS_RST   = 32'h0000_0001;
  localparam logic [31:0] SPEED_RST   = 32'h0000_0010;
  localparam logic [31:0] ACCELERATION_RATE_RST   = 32'h0000_0001;
  localparam logic [31:0] DECELERATION_RATE_RST   = 32'h0000_0001;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================
  // timing: one profile update per servo period
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SERVO_PERIOD_NS = 1000;
  localparam int TICK_CYC        = SERVO_PERIOD_NS / CLK_PERIOD_NS;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    LD_IDLE  = 4'h1,
    LD_SCALE = 4'h2,
    LD_SQRT  = 4'h4,
    LD_WAIT  = 4'h8
  } loader_e;

  typedef struct packed {
    logic [4:0] tempAxis;
    logic [4:0] lastArg;
    logic       tempSel;
    logic       absolute;
  } move_cmd_s;

  typedef struct packed {
    logic [31:0] position;
    logic        busy;
  } axis_demand_s;

endpackage : motion_pkg

// ==== multi_axis_move_generator.sv ====
// Behaviour
// R1: error mask holds one bit per faulted axis; axes 2 and 6 read 68.
// R2: axis faults when its status word hits any selected error condition.
// R3: any motion error switches the global drive enable off.
// R4: first-faulted-axis register keeps the number of the earliest fault.
// R5: error mask also readable as low 16 bits and upper bits separately.
// R6: homing with argument 0 or controller restart clears error state.
// R7: relative move target is current position plus scaled increment.
// R8: multi-axis moves share one path profiled by the base axis.
// R9: absolute move displacement is scaled target minus current position.
// R10: every argument is multiplied by its axis unit factor first.
// R11: argument k drives axis base plus k, in order.
// R12: a move carries one to 32 axis arguments.
// R13: axis rate equals path rate times displacement over path length.
// R14: temporary axis selection overrides default base for one command.
// R15: merge on base keeps speed across consecutive moves.
// R16: separate single-axis moves run independently on own profiles.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module multi_axis_move_generator #(
  parameter int NUM_AXES = 32,
  parameter int STATUS_W = 16,
  parameter int TICK_CYC = motion_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic                            clk_sys,
  input  wire logic                            reset_n,
  // axi4-lite slave
  input  wire logic                            awvalid,
  output logic                                 awready,
  input  wire logic [motion_pkg::AXI_AW-1:0]   awaddr,
  input  wire logic                            wvalid,
  output logic                                 wready,
  input  wire logic [31:0]                     wdata,
  input  wire logic [3:0]                      wstrb,
  output logic                                 bvalid,
  input  wire logic                            bready,
  output logic [1:0]                           bresp,
  input  wire logic                            arvalid,
  output logic                                 arready,
  input  wire logic [motion_pkg::AXI_AW-1:0]   araddr,
  output logic                                 rvalid,
  input  wire logic                            rready,
  output logic [31:0]                          rdata,
  output logic [1:0]                           rresp,
  // servo axes
  input  wire logic [STATUS_W-1:0]             axisStatusWord [NUM_AXES],
  output motion_pkg::axis_demand_s             axisDemand     [NUM_AXES],
  output logic                                 driveEnableSwitch,
  output logic                                 irq
);
  localparam int AX_W = $clog2(NUM_AXES);

  // ==========================================================
  // helpers
  function automatic logic [31:0] strobed(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : strobed

  function automatic logic mapped(input logic [7:0] a);
    return a[7] || (a <= motion_pkg::POS_OFS && a[1:0] == 2'h0
                    && a != 8'h2C && !(a > 8'h38 && a < 8'h40));
  endfunction : mapped

  function automatic logic [31:0] min32(input logic [31:0] a,
                                        input logic [31:0] b);
    return (a < b) ? a : b;
  endfunction : min32

  // trapezoid step: brake when stopping distance reaches what remains
  function automatic logic [31:0] profileStep(input logic [31:0] v,
      input logic [31:0] rem, input logic [31:0] spd,
      input logic [31:0] acc, input logic [31:0] dec, input logic hold);
    logic [63:0] stopSq;
    logic [63:0] room;
    logic [31:0] n;
    stopSq = {32'h0, v} * {32'h0, v};
    room   = ({32'h0, rem} * {32'h0, dec}) << 1;
    if (!hold && stopSq >= room) begin
      n = (v > dec) ? v - dec : 32'h1;
    end else if (v < spd) begin
      n = min32(v + acc, spd);
    end else begin
      n = spd;
    end
    if (n == 32'h0) n = 32'h1;
    return min32(n, rem);
  endfunction : profileStep

  function automatic logic [AX_W-1:0] firstSet(input logic [NUM_AXES-1:0] m);
    logic [AX_W-1:0] r;
    r = '0;
    for (int k = NUM_AXES - 1; k >= 0; k--) begin
      if (m[k]) r = AX_W'(k);
    end
    return r;
  endfunction : firstSet

  // ==========================================================
  // registers and state
  logic                    bvalidQ, rvalidQ;
  logic [1:0]              brespQ, rrespQ;
  logic [31:0]             rdataQ;
  logic [AX_W-1:0]         baseQ, axSelQ;
  logic                    driveQ;
  logic [31:0]             errSelQ;
  logic [NUM_AXES-1:0]     errMaskQ;
  logic [AX_W-1:0]         firstAxisQ;
  logic [motion_pkg::IRQ_W-1:0] irqStQ, irqEnQ;
  logic [31:0]             argQ    [32];
  logic [31:0]             unitsQ  [NUM_AXES];
  logic [31:0]             speedQ  [NUM_AXES];
  logic [31:0]             accelQ  [NUM_AXES];
  logic [31:0]             decelQ  [NUM_AXES];
  logic                    mergeQ  [NUM_AXES];
  logic [STATUS_W-1:0]     stMeta  [NUM_AXES];
  logic [STATUS_W-1:0]     stSync  [NUM_AXES];
  logic [31:0]             posQ    [NUM_AXES];
  logic [31:0]             magQ    [NUM_AXES];
  logic [31:0]             accQ    [NUM_AXES];
  logic [31:0]             pathQ   [NUM_AXES];
  logic [31:0]             doneQ   [NUM_AXES];
  logic [31:0]             velQ    [NUM_AXES];
  logic [31:0]             budgetQ [NUM_AXES];
  logic [AX_W-1:0]         ownerQ  [NUM_AXES];
  logic                    dirQ    [NUM_AXES];
  logic                    busyQ   [NUM_AXES];
  logic [31:0]             stageQ  [NUM_AXES];
  logic [NUM_AXES-1:0]     stageSelQ;
  motion_pkg::loader_e     ldState;
  motion_pkg::move_cmd_s   cmdQ;
  logic [AX_W-1:0]         ldBase;
  logic [4:0]              ldIdx, bitIdx;
  logic [63:0]             sumSqQ;
  logic [31:0]             rootQ;
  logic [15:0]             tickCnt;
  logic                    tick;
  wire  [NUM_AXES-1:0]     busyVec, mstep, lastStep, errNow;

  // ==========================================================
  // axi4-lite handshakes
  wire       wrFire = awvalid && wvalid && !bvalidQ;
  wire       rdFire = arvalid && !rvalidQ;
  wire [7:0] wa     = awaddr;
  assign awready = wrFire;
  assign wready  = wrFire;
  assign arready = !rvalidQ;
  assign bvalid  = bvalidQ;
  assign bresp   = brespQ;
  assign rvalid  = rvalidQ;
  assign rdata   = rdataQ;
  assign rresp   = rrespQ;

  wire wCmd     = wrFire && wa == motion_pkg::CMD_OFS;
  wire wHome0   = wrFire && wa == motion_pkg::HOME_OFS && wdata == 32'h0;
  wire wRestart = wrFire && wa == motion_pkg::RESTART_OFS;
  wire clrErr   = wHome0 || wRestart;
  wire errAny   = |errNow;
  wire runOk    = driveQ && !errAny;
  wire ldIdle   = ldState == motion_pkg::LD_IDLE;
  wire commit   = ldState == motion_pkg::LD_WAIT
                  && (stageSelQ & busyVec) == '0;

  // write response, unmapped addresses answer slverr
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bvalidQ <= 1'b0;
      brespQ  <= motion_pkg::RESP_OKAY;
    end else if (wrFire) begin
      bvalidQ <= 1'b1;
      brespQ  <= mapped(wa) ? motion_pkg::RESP_OKAY : motion_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalidQ <= 1'b0;
    end
  end

  // read data mux
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    unique case (araddr)
      motion_pkg::BASE_OFS:   rdMux = 32'(baseQ);
      motion_pkg::DRIVE_OFS:  rdMux = 32'(driveQ);
      motion_pkg::ERRSEL_OFS: rdMux = errSelQ;
      motion_pkg::ERRALL_OFS: rdMux = 32'(errMaskQ);                     // [R1]
      motion_pkg::ERRLO_OFS:  rdMux = {16'h0, 16'(errMaskQ)};            // [R5]
      motion_pkg::ERRHI_OFS:  rdMux = 32'(errMaskQ) >> motion_pkg::ERR_SPLIT; // [R5]
      motion_pkg::FIRST_OFS:  rdMux = 32'(firstAxisQ);                   // [R4]
      motion_pkg::STAT_OFS:   rdMux = {29'h0, !ldIdle, |busyVec, runOk};
      motion_pkg::IRQST_OFS:  rdMux = 32'(irqStQ);
      motion_pkg::IRQEN_OFS:  rdMux = 32'(irqEnQ);
      motion_pkg::AXSEL_OFS:  rdMux = 32'(axSelQ);
      motion_pkg::UNITS_OFS:  rdMux = unitsQ[axSelQ];
      motion_pkg::SPEED_OFS:  rdMux = speedQ[axSelQ];
      motion_pkg::ACCELERATION_RATE_OFS:  rdMux = accelQ[axSelQ];
      motion_pkg::DECELERATION_RATE_OFS:  rdMux = decelQ[axSelQ];
      motion_pkg::MERGE_OFS:  rdMux = 32'(mergeQ[axSelQ]);
      motion_pkg::POS_OFS:    rdMux = posQ[axSelQ];
      default: if (araddr[7]) rdMux = argQ[araddr[6:2]];
    endcase
  end

  // read response
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rvalidQ <= 1'b0;
      rdataQ  <= 32'h0;
      rrespQ  <= motion_pkg::RESP_OKAY;
    end else if (rdFire) begin
      rvalidQ <= 1'b1;
      rdataQ  <= rdMux;
      rrespQ  <= mapped(araddr) ? motion_pkg::RESP_OKAY : motion_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalidQ <= 1'b0;
    end
  end

  // ==========================================================
  // software-written settings
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      baseQ   <= '0;
      axSelQ  <= '0;
      errSelQ <= 32'h0;
      irqEnQ  <= '0;
      for (int k = 0; k < 32; k++) argQ[k] <= 32'h0;
      for (int k = 0; k < NUM_AXES; k++) begin
        unitsQ[k] <= motion_pkg::UNITS_RST;
        speedQ[k] <= motion_pkg::SPEED_RST;
        accelQ[k] <= motion_pkg::ACCELERATION_RATE_RST;
        decelQ[k] <= motion_pkg::DECELERATION_RATE_RST;
        mergeQ[k] <= 1'b0;
      end
    end else if (wrFire) begin
      unique case (wa)
        motion_pkg::BASE_OFS:   baseQ   <= wdata[AX_W-1:0];
        motion_pkg::AXSEL_OFS:  axSelQ  <= wdata[AX_W-1:0];
        motion_pkg::ERRSEL_OFS: errSelQ <= strobed(errSelQ, wdata, wstrb);
        motion_pkg::IRQEN_OFS:  irqEnQ  <= wdata[motion_pkg::IRQ_W-1:0];
        motion_pkg::UNITS_OFS:  unitsQ[axSelQ] <= strobed(unitsQ[axSelQ], wdata, wstrb);
        motion_pkg::SPEED_OFS:  speedQ[axSelQ] <= strobed(speedQ[axSelQ], wdata, wstrb);
        motion_pkg::ACCELERATION_RATE_OFS:  accelQ[axSelQ] <= strobed(accelQ[axSelQ], wdata, wstrb);
        motion_pkg::DECELERATION_RATE_OFS:  decelQ[axSelQ] <= strobed(decelQ[axSelQ], wdata, wstrb);
        motion_pkg::MERGE_OFS:  mergeQ[axSelQ] <= wdata[0];
        default: if (wa[7]) argQ[wa[6:2]] <= strobed(argQ[wa[6:2]], wdata, wstrb);
      endcase
    end
  end

  // ==========================================================
  // motion errors
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < NUM_AXES; k++) begin
        stMeta[k] <= '0;
        stSync[k] <= '0;
      end
    end else begin
      for (int k = 0; k < NUM_AXES; k++) begin
        stMeta[k] <= axisStatusWord[k];
        stSync[k] <= stMeta[k];
      end
    end
  end

  for (genvar e = 0; e < NUM_AXES; e++) begin : g_err
    assign errNow[e] = |(stSync[e] & STATUS_W'(errSelQ)); // [R2]
  end

  // sticky mask, a new fault outweighs a clear in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      errMaskQ   <= '0;
      firstAxisQ <= '0;
    end else begin
      errMaskQ <= (clrErr ? '0 : errMaskQ) | errNow; // [R1] [R6]
      if ((clrErr || errMaskQ == '0) && errAny) begin
        firstAxisQ <= firstSet(errNow); // [R4]
      end else if (clrErr) begin
        firstAxisQ <= '0; // [R6]
      end
    end
  end

  // global drive enable, forced off by any fault
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      driveQ <= 1'b0;
    end else if (errAny) begin
      driveQ <= 1'b0; // [R3]
    end else if (wrFire && wa == motion_pkg::DRIVE_OFS && wstrb[0]) begin
      driveQ <= wdata[0];
    end
  end
  assign driveEnableSwitch = driveQ;

  // interrupt status, set wins over clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irqStQ <= '0;
    end else begin
      irqStQ <= (irqStQ & ~((wrFire && wa == motion_pkg::IRQCLR_OFS)
                 ? wdata[motion_pkg::IRQ_W-1:0] : '0))
                | {wCmd && !ldIdle, |lastStep, errAny && !(&errMaskQ)};
    end
  end
  assign irq = |(irqStQ & irqEnQ);

  // ==========================================================
  // servo tick divider
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt <= 16'h0;
      tick    <= 1'b0;
    end else begin
      tick    <= tickCnt == 16'(TICK_CYC - 1);
      tickCnt <= (tickCnt == 16'(TICK_CYC - 1)) ? 16'h0 : tickCnt + 16'h1;
    end
  end

  // ==========================================================
  // command loader: scale, displacement, path length
  wire [AX_W-1:0]    ldAx   = ldBase + AX_W'(ldIdx);          // [R11]
  wire [63:0]        edges  = {{32{argQ[ldIdx][31]}}, argQ[ldIdx]}
                              * {32'h0, unitsQ[ldAx]};        // [R10]
  wire [31:0]        delta  = cmdQ.absolute
                              ? edges[31:0] - posQ[ldAx]      // [R9]
                              : edges[31:0];                  // [R7]
  wire signed [63:0] dExt   = {{32{delta[31]}}, delta};
  wire [63:0]        dSq    = 64'(dExt * dExt);
  wire [31:0]        trial  = rootQ | (32'h1 << bitIdx);
  wire [63:0]        trialSq = {32'h0, trial} * {32'h0, trial};

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ldState   <= motion_pkg::LD_IDLE;
      cmdQ      <= '0;
      ldBase    <= '0;
      ldIdx     <= 5'h0;
      bitIdx    <= 5'h0;
      sumSqQ    <= 64'h0;
      rootQ     <= 32'h0;
      stageSelQ <= '0;
      for (int k = 0; k < NUM_AXES; k++) stageQ[k] <= 32'h0;
    end else if (wRestart) begin
      ldState   <= motion_pkg::LD_IDLE;
      stageSelQ <= '0;
    end else begin
      unique case (ldState)
        motion_pkg::LD_IDLE: if (wCmd) begin
          cmdQ      <= {wdata[20:16], wdata[12:8], wdata[1:0]}; // [R12]
          ldBase    <= wdata[1] ? wdata[16 +: AX_W] : baseQ;  // [R14]
          ldIdx     <= 5'h0;
          sumSqQ    <= 64'h0;
          rootQ     <= 32'h0;
          stageSelQ <= '0;
          ldState   <= motion_pkg::LD_SCALE;
        end
        motion_pkg::LD_SCALE: begin
          stageQ[ldAx]    <= delta;
          stageSelQ[ldAx] <= 1'b1;
          sumSqQ          <= sumSqQ + dSq;                    // [R13]
          ldIdx           <= ldIdx + 5'h1;
          if (ldIdx == cmdQ.lastArg) begin
            bitIdx  <= 5'h1F;
            ldState <= motion_pkg::LD_SQRT;
          end
        end
        motion_pkg::LD_SQRT: begin
          if (trialSq <= sumSqQ) rootQ <= trial;
          bitIdx <= bitIdx - 5'h1;
          if (bitIdx == 5'h0) ldState <= motion_pkg::LD_WAIT;
        end
        motion_pkg::LD_WAIT: if (commit) begin
          stageSelQ <= '0;
          ldState   <= motion_pkg::LD_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // per-axis profile and interpolation
  for (genvar i = 0; i < NUM_AXES; i++) begin : g_axis
    wire [AX_W-1:0] own     = ownerQ[i];
    wire            isBase  = busyQ[i] && own == AX_W'(i);
    wire [32:0]     accSum  = {1'b0, accQ[i]} + {1'b0, magQ[i]};
    wire            stepHit = accSum >= {1'b0, pathQ[own]};
    wire            hold    = mergeQ[i] && ldState == motion_pkg::LD_WAIT
                              && ldBase == AX_W'(i);          // [R15]
    wire [31:0]     spd     = min32(speedQ[i], 32'(TICK_CYC - 1));
    wire [31:0]     vNext   = profileStep(velQ[i], pathQ[i] - doneQ[i], spd,
                                          accelQ[i], decelQ[i], hold); // [R8] [R16]
    wire            go      = commit && stageSelQ[i];

    assign busyVec[i]  = busyQ[i];
    assign mstep[i]    = isBase && budgetQ[i] != 32'h0 && runOk;
    assign lastStep[i] = mstep[i] && doneQ[i] + 32'h1 == pathQ[i];
    assign axisDemand[i] = '{position: posQ[i], busy: busyQ[i]};

    // position follows the base axis path steps
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        posQ[i]   <= 32'h0;
        accQ[i]   <= 32'h0;
        magQ[i]   <= 32'h0;
        dirQ[i]   <= 1'b0;
        ownerQ[i] <= AX_W'(i);
        busyQ[i]  <= 1'b0;
      end else if (wRestart) begin
        busyQ[i] <= 1'b0;
      end else if (go) begin
        ownerQ[i] <= ldBase;
        magQ[i]   <= stageQ[i][31] ? -stageQ[i] : stageQ[i];
        dirQ[i]   <= stageQ[i][31];
        accQ[i]   <= 32'h0;
        busyQ[i]  <= 1'b1;
      end else if (busyQ[i] && mstep[own]) begin
        if (stepHit) begin
          accQ[i] <= 32'(accSum - {1'b0, pathQ[own]});
          posQ[i] <= dirQ[i] ? posQ[i] - 32'h1 : posQ[i] + 32'h1; // [R13]
        end else begin
          accQ[i] <= accSum[31:0];
        end
        if (lastStep[own]) busyQ[i] <= 1'b0;
      end
    end

    // path profile, live only while this axis is a base
    always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
        pathQ[i]   <= 32'h1;
        doneQ[i]   <= 32'h0;
        velQ[i]    <= 32'h0;
        budgetQ[i] <= 32'h0;
      end else if (wRestart) begin
        velQ[i]    <= 32'h0;
        budgetQ[i] <= 32'h0;
      end else if (go && ldBase == AX_W'(i)) begin
        pathQ[i]   <= (rootQ == 32'h0) ? 32'h1 : rootQ;      // [R8]
        doneQ[i]   <= 32'h0;
        budgetQ[i] <= 32'h0;
      end else if (isBase && tick && runOk) begin
        velQ[i]    <= vNext;
        budgetQ[i] <= vNext;
      end else if (mstep[i]) begin
        doneQ[i]   <= doneQ[i] + 32'h1;
        budgetQ[i] <= budgetQ[i] - 32'h1;
        if (lastStep[i] && !hold) velQ[i] <= 32'h0;           // [R15]
      end
    end
  end

endmodule : multi_axis_move_generator

// ==== multi_axis_move_generator_assertions.sv ====
`timescale 1ns/10ps
module multi_axis_move_generator_assertions #(
  parameter int NUM_AXES = 32,
  parameter int STATUS_W = 16
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // register bus
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic [7:0] awaddr,
  input wire logic       wvalid,
  input wire logic [31:0] wdata,
  input wire logic       bvalid,
  input wire logic       bready,
  input wire logic [1:0] bresp,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic [7:0] araddr,
  input wire logic       rvalid,
  input wire logic       rready,
  input wire logic [31:0] rdata,
  // servo side
  input wire logic [STATUS_W-1:0] axisStatusWord [NUM_AXES],
  input wire logic       driveEnableSwitch
);
  // ==========
  // error selection shadow
  logic [STATUS_W-1:0] errSel_q;
  logic                errHit;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) errSel_q <= '0;
    else if (awvalid && wvalid && awready && awaddr == motion_pkg::ERRSEL_OFS)
      errSel_q <= wdata[STATUS_W-1:0];
  end
  // any axis matching a selected condition
  always_comb begin
    errHit = 1'h0;
    for (int i = 0; i < NUM_AXES; i++) errHit |= |(axisStatusWord[i] & errSel_q);
  end
  // ==========
  // properties
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  sequence wrTake;
    awvalid && wvalid && awready;
  endsequence
  sequence rdTake;
    arvalid && arready;
  endsequence
  wr_answer_a: assert property (wrTake |=> bvalid)
    else $error("write not answered");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  rd_answer_a: assert property (rdTake |=> rvalid)
    else $error("read not answered");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  unmapped_resp_a: assert property (wrTake ##0 awaddr == 8'h2C |=> bresp == 2'h2)
    else $error("unmapped write not refused");
  err_lo_a: assert property (rdTake ##0 araddr == 8'h14 |=> rdata[31:16] == 16'h0)
    else $error("low error part too wide");
  err_hi_a: assert property (rdTake ##0 araddr == 8'h18 |=> rdata[31:16] == 16'h0)
    else $error("high error part too wide");
  drive_off_a: assert property ($rose(errHit) |-> ##[1:6] !driveEnableSwitch)
    else $error("drive stays on after error");
endmodule : multi_axis_move_generator_assertions

bind multi_axis_move_generator multi_axis_move_generator_assertions #(
  .NUM_AXES(NUM_AXES), .STATUS_W(STATUS_W)
) i_chk (
  .clk_sys, .reset_n, .awvalid, .awready, .awaddr, .wvalid, .wdata, .bvalid,
  .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
  .axisStatusWord, .driveEnableSwitch
);

// ==== multi_axis_move_generator_tb.sv ====
`timescale 1ns/10ps
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin errTotal++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module multi_axis_move_generator_tb;
  logic        clk_sys = 1'h0, reset_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
  logic        bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, driveEnableSwitch, irq;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, faultAxes = 32'h0, rdata, rd;
  logic [1:0]  bresp, rresp;
  logic [15:0] axisStatusWord [32];
  logic [31:0] expPos [32];
  int          errTotal = 0, checksDone = 0, cycles = 0;
  motion_pkg::axis_demand_s axisDemand [32];
  // ==========
  // block, servo axes and clock
  multi_axis_move_generator #(.TICK_CYC(8)) i_dut (
    .clk_sys, .reset_n, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .axisStatusWord, .axisDemand, .driveEnableSwitch, .irq);
  servo_axes_model i_axes (.faultAxes, .axisStatusWord);
  always #5 clk_sys = ~clk_sys;
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      errTotal++;
      finishTest();
    end
  end
  // ==========
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do @(posedge clk_sys); while (!awready);
    awvalid <= 1'h0;
    wvalid  <= 1'h0;
    do @(posedge clk_sys); while (!bvalid);
    bready  <= 1'h0;
  endtask : wr
  task automatic rdw(input logic [7:0] a);
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clk_sys); while (!rvalid);
    rd = rdata;
    rready  <= 1'h0;
  endtask : rdw
  // poll until loader and axes are idle, then compare all positions
  task automatic settle();
    do rdw(motion_pkg::STAT_OFS); while (rd[2:1] !== 2'h0);
    for (int i = 0; i < 32; i++) `CHK("pos", expPos[i], axisDemand[i].position)
  endtask : settle
  task automatic finishTest();
    $display("checks %0d errors %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finishTest
  // ==========
  // main sequence
  initial begin
    foreach (expPos[i]) expPos[i] = 32'h0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'h1;
    wr(motion_pkg::DRIVE_OFS, 32'h1);
    wr(motion_pkg::BASE_OFS, 32'h3);
    wr(motion_pkg::AXSEL_OFS, 32'h4);
    wr(motion_pkg::UNITS_OFS, 32'h3);
    wr(motion_pkg::ARG_OFS, 32'h5);
    wr(8'h84, 32'h2);
    wr(motion_pkg::CMD_OFS, 32'h100);
    expPos[3] = 32'h5;
    expPos[4] = 32'h6;
    settle();
    wr(motion_pkg::ARG_OFS, 32'h2);
    wr(8'h84, 32'h1);
    wr(motion_pkg::CMD_OFS, 32'h101);
    expPos[3] = 32'h2;
    expPos[4] = 32'h3;
    settle();
    wr(motion_pkg::ARG_OFS, 32'h7);
    wr(motion_pkg::CMD_OFS, 32'hA_0002);
    expPos[10] = 32'h7;
    settle();
    for (int k = 0; k < 32; k++) begin
      wr(8'(motion_pkg::ARG_OFS + 4 * k), 32'h1);
      expPos[(3 + k) % 32] += (k == 1) ? 32'h3 : 32'h1;
    end
    wr(motion_pkg::CMD_OFS, 32'h1F00);
    settle();
    wr(motion_pkg::ERRSEL_OFS, 32'h1);
    wr(motion_pkg::IRQEN_OFS, 32'h1);
    faultAxes <= 32'h44;
    repeat (8) @(posedge clk_sys);
    rdw(motion_pkg::ERRALL_OFS);
    `CHK("errall", 32'h44, rd)
    rdw(motion_pkg::FIRST_OFS);
    `CHK("first", 32'h2, rd)
    `CHK("drive", 1'h0, driveEnableSwitch)
    `CHK("irq", 1'h1, irq)
    faultAxes <= 32'h2_0044;
    repeat (8) @(posedge clk_sys);
    rdw(motion_pkg::ERRLO_OFS);
    `CHK("errlo", 32'h44, rd)
    rdw(motion_pkg::ERRHI_OFS);
    `CHK("errhi", 32'h2, rd)
    rdw(motion_pkg::FIRST_OFS);
    `CHK("first2", 32'h2, rd)
    faultAxes <= 32'h0;
    repeat (8) @(posedge clk_sys);
    wr(motion_pkg::HOME_OFS, 32'h1);
    rdw(motion_pkg::ERRALL_OFS);
    `CHK("home1", 32'h2_0044, rd)
    wr(motion_pkg::HOME_OFS, 32'h0);
    wr(motion_pkg::IRQCLR_OFS, 32'h1);
    rdw(motion_pkg::ERRALL_OFS);
    `CHK("home0", 32'h0, rd)
    `CHK("irqclr", 1'h0, irq)
    faultAxes <= 32'h1;
    repeat (8) @(posedge clk_sys);
    faultAxes <= 32'h0;
    repeat (8) @(posedge clk_sys);
    wr(motion_pkg::RESTART_OFS, 32'h0);
    rdw(motion_pkg::ERRALL_OFS);
    `CHK("restart", 32'h0, rd)
    wr(8'h2C, 32'h5);
    rdw(8'h2C);
    `CHK("unmapped", 32'h0, rd)
    finishTest();
  end
endmodule : multi_axis_move_generator_tb

// ==== servo_axes_model.sv ====
`timescale 1ns/10ps
module servo_axes_model #(
  parameter int NUM_AXES = 32
) (
  // fault request from the bench
  input  wire logic [31:0] faultAxes,
  // toward the block
  output logic [15:0]      axisStatusWord [NUM_AXES]
);
  // status bit0 flags a drive fault
  always_comb begin
    for (int i = 0; i < NUM_AXES; i++) axisStatusWord[i] = {15'h0, faultAxes[i]};
  end
endmodule : servo_axes_model
